// ==== logic/wbc_cache_ctrl.sv ====
// Split instruction and write-back data cache controller with a Wishbone control slave.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_params.svh"
module wbc_cache_ctrl
  import wbc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        core_req,
  input  wire logic        core_ifetch,
  input  wire logic        core_we,
  input  wire logic [31:0] core_va,
  input  wire logic [31:0] core_pa,
  input  wire logic [3:0]  core_be,
  input  wire logic [31:0] core_wdata,
  output logic             core_ack,
  output logic             core_err,
  output logic      [31:0] core_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [31:0] mem_rdata
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [9:0] line_index(input logic [31:0] va, input logic dc);
    return dc ? {1'h0, va[`WBC_DC_IDX_MSB:`WBC_IDX_LSB]} : va[`WBC_IC_IDX_MSB:`WBC_IDX_LSB];
  endfunction

  // ****************************************************************
  // Line storage
  // ****************************************************************
  // Arrays carry no reset, so software must invalidate every line first.
  // Only the core port and the maintenance engine reach them.
  wbc_physical_tag_field_t   ic_tag  [0:`WBC_IC_LINES-1];
  logic        ic_v    [0:`WBC_IC_LINES-1];
  logic        ic_tp   [0:`WBC_IC_LINES-1];
  logic [31:0] ic_data [0:`WBC_IC_LINES-1][0:`WBC_LINE_WORDS-1];
  wbc_physical_tag_field_t   dc_tag  [0:`WBC_DC_LINES-1];
  logic        dc_v    [0:`WBC_DC_LINES-1];
  logic        dc_d    [0:`WBC_DC_LINES-1];
  logic        dc_w    [0:`WBC_DC_LINES-1];
  logic        dc_tp   [0:`WBC_DC_LINES-1];
  logic [31:0] dc_data [0:`WBC_DC_LINES-1][0:`WBC_LINE_WORDS-1];
  logic        dc_dp   [0:`WBC_DC_LINES-1][0:`WBC_LINE_WORDS-1];

  // ****************************************************************
  // Registers
  // ****************************************************************
  wbc_state_t  state_q, state_d;
  logic [9:0]  idx_q, idx_d;
  logic        dc_q, dc_d_sel;
  logic [27:0] line_q, line_d;
  wbc_physical_tag_field_t   vtag_q, vtag_d;
  logic [1:0]  beat_q, beat_d;
  logic        maint_q, maint_d;
  logic        core_ack_q, core_ack_d;
  logic        core_err_q, core_err_d;
  logic [31:0] core_rdata_q, core_rdata_d;
  logic        wb_ack_q, wb_ack_d;
  logic [31:0] wb_dat_q, wb_dat_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [31:0] maddr_q, maddr_d;
  logic        mpend_q, mpend_d;
  wbc_mop_t    mop_q, mop_d;
  logic        mdc_q, mdc_d;
  logic [2:0]  sticky_q, sticky_d;

  // ****************************************************************
  // Lookup of the addressed line
  // ****************************************************************
  logic        core_sel, lk_dc, ic_hit, dc_hit, ic_terr, dc_terr, hit;
  logic [31:0] lk_va, lk_pa;
  logic [9:0]  lk_idx;
  logic [1:0]  lk_word;
  logic        dp_err;

  always_comb begin
    core_sel = core_req & ~core_ack_q;
    lk_dc    = core_sel ? ~core_ifetch : mdc_q;
    lk_va    = core_sel ? core_va : maddr_q;
    lk_pa    = core_sel ? core_pa : maddr_q;
    lk_idx   = line_index(lk_va, lk_dc);
    lk_word  = lk_va[3:2];
    hit      = lk_dc ? dc_hit : ic_hit;
    // Data check on the word leaving during a write-back.
    dp_err   = dc_dp[idx_q[8:0]][beat_q] != ^dc_data[idx_q[8:0]][beat_q];
  end

  wbc_tag_check u_ic_chk (
    .stored_tag   (ic_tag[lk_idx]),
    .stored_flags ({ic_v[lk_idx], 2'h0}),
    .stored_par   (ic_tp[lk_idx]),
    .pa_tag       (lk_pa[31:`WBC_PHYSICAL_TAG_FIELD_LSB]),
    .hit          (ic_hit),
    .tag_err      (ic_terr)
  );

  wbc_tag_check u_dc_chk (
    .stored_tag   (dc_tag[lk_idx[8:0]]),
    .stored_flags ({dc_v[lk_idx[8:0]], dc_d[lk_idx[8:0]], dc_w[lk_idx[8:0]]}),
    .stored_par   (dc_tp[lk_idx[8:0]]),
    .pa_tag       (lk_pa[31:`WBC_PHYSICAL_TAG_FIELD_LSB]),
    .hit          (dc_hit),
    .tag_err      (dc_terr)
  );

  // ****************************************************************
  // Cache sequencer
  // ****************************************************************
  logic        ic_tw, dc_tw, ic_dw, dc_dw, inv_lk, mdone, need_wb;
  logic [9:0]  tw_idx, dw_idx;
  wbc_physical_tag_field_t   tw_tag;
  logic        tw_v, tw_w;
  logic [1:0]  dw_word;
  logic [31:0] dw_data;
  logic        ev_tag_err, ev_data_err, ev_bus_err;

  always_comb begin
    state_d      = state_q;
    idx_d        = idx_q;
    dc_d_sel     = dc_q;
    line_d       = line_q;
    vtag_d       = vtag_q;
    beat_d       = beat_q;
    maint_d      = maint_q;
    core_ack_d   = 1'h0;
    core_err_d   = 1'h0;
    core_rdata_d = core_rdata_q;
    ic_tw        = 1'h0;
    dc_tw        = 1'h0;
    ic_dw        = 1'h0;
    dc_dw        = 1'h0;
    inv_lk       = 1'h0;
    mdone        = 1'h0;
    tw_idx       = idx_q;
    tw_tag       = vtag_q;
    tw_v         = 1'h0;
    tw_w         = 1'h0;
    dw_idx       = idx_q;
    dw_word      = beat_q;
    dw_data      = mem_rdata;
    ev_tag_err   = 1'h0;
    ev_data_err  = 1'h0;
    ev_bus_err   = 1'h0;
    need_wb      = lk_dc & dc_v[lk_idx[8:0]] & dc_w[lk_idx[8:0]];
    unique case (state_q)
      WBC_IDLE: begin
        idx_d    = lk_idx;
        dc_d_sel = lk_dc;
        line_d   = lk_pa[31:4];
        vtag_d   = dc_tag[lk_idx[8:0]];
        beat_d   = 2'h0;
        if (core_sel) begin
          maint_d = 1'h0;
          if (hit) begin
            // Plain reads leave the line state alone.
            core_ack_d   = 1'h1;
            core_rdata_d = lk_dc ? dc_data[lk_idx[8:0]][lk_word] : ic_data[lk_idx][lk_word];
            if (lk_dc & core_we) begin
              // Store stays in the line and marks it dirty.
              dc_dw   = 1'h1;
              dw_idx  = lk_idx;
              dw_word = lk_word;
              dw_data = merge_be(dc_data[lk_idx[8:0]][lk_word], core_wdata, core_be);
              dc_tw   = 1'h1;
              tw_idx  = lk_idx;
              tw_tag  = dc_tag[lk_idx[8:0]];
              tw_v    = 1'h1;
              tw_w    = 1'h1;
            end
          end else if (need_wb) begin
            if (dc_terr) begin
              // No bus cycle for a victim whose tag cannot be trusted.
              ev_tag_err = 1'h1;
              core_ack_d = 1'h1;
              core_err_d = 1'h1;
            end else begin
              state_d = WBC_WB;
            end
          end else begin
            // Clean or invalid victim: drop it and refill directly.
            inv_lk  = 1'h1;
            state_d = WBC_RF;
          end
        end else if (mpend_q) begin
          maint_d = 1'h1;
          need_wb = need_wb & ((mop_q == WBC_OP_IDX_WBINV) |
                               ((mop_q == WBC_OP_HIT_WBINV) & hit));
          if (need_wb) begin
            if (dc_terr) begin
              ev_tag_err = 1'h1;
              mdone      = 1'h1;
            end else begin
              state_d = WBC_WB;
            end
          end else begin
            inv_lk = (mop_q == WBC_OP_IDX_INV) | (mop_q == WBC_OP_IDX_WBINV) | hit;
            mdone  = 1'h1;
          end
        end
      end
      WBC_WB: begin
        if (mem_ack) begin
          // Faulty data still goes out; maintenance skips the data check.
          ev_data_err = dp_err & ~maint_q;
          ev_bus_err  = mem_err;
          beat_d      = beat_q + 2'h1;
          if (beat_q == `WBC_LAST_BEAT) begin
            dc_tw  = 1'h1;
            tw_tag = vtag_q;
            if (maint_q) begin
              mdone   = 1'h1;
              state_d = WBC_IDLE;
            end else begin
              state_d = WBC_RF;
            end
          end
        end
      end
      WBC_RF: begin
        if (mem_ack) begin
          if (mem_err) begin
            // Line stays invalid and the core sees an error answer.
            ev_bus_err = 1'h1;
            core_ack_d = 1'h1;
            core_err_d = 1'h1;
            state_d    = WBC_IDLE;
          end else begin
            ic_dw  = ~dc_q;
            dc_dw  = dc_q;
            beat_d = beat_q + 2'h1;
            if (beat_q == `WBC_LAST_BEAT) begin
              // Tag goes valid and clean only after the fourth word.
              ic_tw   = ~dc_q;
              dc_tw   = dc_q;
              tw_tag  = line_q[27:6];
              tw_v    = 1'h1;
              state_d = WBC_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = WBC_IDLE;
      end
    endcase
    if (inv_lk) begin
      ic_tw  = ~lk_dc;
      dc_tw  = lk_dc;
      tw_idx = lk_idx;
      tw_tag = lk_dc ? dc_tag[lk_idx[8:0]] : ic_tag[lk_idx];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q      <= WBC_IDLE;
      idx_q        <= 10'h000;
      dc_q         <= 1'h0;
      line_q       <= 28'h000_0000;
      vtag_q       <= 22'h00_0000;
      beat_q       <= 2'h0;
      maint_q      <= 1'h0;
      core_ack_q   <= 1'h0;
      core_err_q   <= 1'h0;
      core_rdata_q <= 32'h0000_0000;
    end else begin
      state_q      <= state_d;
      idx_q        <= idx_d;
      dc_q         <= dc_d_sel;
      line_q       <= line_d;
      vtag_q       <= vtag_d;
      beat_q       <= beat_d;
      maint_q      <= maint_d;
      core_ack_q   <= core_ack_d;
      core_err_q   <= core_err_d;
      core_rdata_q <= core_rdata_d;
    end
  end

  // Storage writes; dirty mirrors line-modified, parity may be spoiled for test.
  always_ff @(posedge sys_clk) begin
    if (ic_tw) begin
      ic_tag[tw_idx] <= tw_tag;
      ic_v[tw_idx]   <= tw_v;
      ic_tp[tw_idx]  <= ^{tw_tag, tw_v, 2'h0} ^ ctrl_q[`WBC_CTRL_INJ_TAG];
    end
    if (dc_tw) begin
      dc_tag[tw_idx[8:0]] <= tw_tag;
      dc_v[tw_idx[8:0]]   <= tw_v;
      dc_d[tw_idx[8:0]]   <= tw_w;
      dc_w[tw_idx[8:0]]   <= tw_w;
      dc_tp[tw_idx[8:0]]  <= ^{tw_tag, tw_v, tw_w, tw_w} ^ ctrl_q[`WBC_CTRL_INJ_TAG];
    end
    if (ic_dw) begin
      ic_data[dw_idx][dw_word] <= dw_data;
    end
    if (dc_dw) begin
      dc_data[dw_idx[8:0]][dw_word] <= dw_data;
      dc_dp[dw_idx[8:0]][dw_word]   <= ^dw_data ^ ctrl_q[`WBC_CTRL_INJ_DATA];
    end
  end

  // ****************************************************************
  // Wishbone control slave
  // ****************************************************************
  logic        wb_wr;
  logic [31:0] ctrl_m;

  always_comb begin
    wb_ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    wb_wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_q;
    ctrl_m   = merge_be({30'h0000_0000, ctrl_q}, wb_dat_i, wb_sel_i);
    wb_dat_d = wb_dat_q;
    ctrl_d   = ctrl_q;
    maddr_d  = maddr_q;
    mpend_d  = mpend_q & ~mdone;
    mop_d    = mop_q;
    mdc_d    = mdc_q;
    // A flag raised in the cycle of its clear survives.
    sticky_d = sticky_q | {ev_bus_err, ev_data_err, ev_tag_err};
    if (wb_ack_d) begin
      unique case (wb_adr_i)
        `WBC_OFS_CTRL:  wb_dat_d = {30'h0000_0000, ctrl_q};
        `WBC_OFS_CMD:   wb_dat_d = {27'h000_0000, mdc_q, 2'h0, mop_q};
        `WBC_OFS_MADDR: wb_dat_d = maddr_q;
        `WBC_OFS_STAT:  wb_dat_d = {28'h000_0000, sticky_q, mpend_q};
        default:        wb_dat_d = 32'h0000_0000;
      endcase
    end
    if (wb_wr) begin
      unique case (wb_adr_i)
        `WBC_OFS_CTRL: begin
          ctrl_d = ctrl_m[1:0];
        end
        `WBC_OFS_CMD: begin
          // A command while one is pending is dropped; poll busy first.
          if (~mpend_q & wb_sel_i[0]) begin
            mpend_d = 1'h1;
            mop_d   = wbc_mop_t'(wb_dat_i[`WBC_CMD_OP_MSB:`WBC_CMD_OP_LSB]);
            mdc_d   = wb_dat_i[`WBC_CMD_DC];
          end
        end
        `WBC_OFS_MADDR: begin
          maddr_d = merge_be(maddr_q, wb_dat_i, wb_sel_i);
        end
        `WBC_OFS_STAT: begin
          if (wb_sel_i[0]) begin
            sticky_d = (sticky_q & ~wb_dat_i[`WBC_STAT_BUS_ERR:`WBC_STAT_TAG_ERR]) |
                       {ev_bus_err, ev_data_err, ev_tag_err};
          end
        end
        default: begin
          sticky_d = sticky_d;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_q <= 1'h0;
      wb_dat_q <= 32'h0000_0000;
      ctrl_q   <= `WBC_CTRL_RST;
      maddr_q  <= `WBC_MADDR_RST;
      mpend_q  <= 1'h0;
      mop_q    <= WBC_OP_IDX_INV;
      mdc_q    <= 1'h0;
      sticky_q <= `WBC_STICKY_RST;
    end else begin
      wb_ack_q <= wb_ack_d;
      wb_dat_q <= wb_dat_d;
      ctrl_q   <= ctrl_d;
      maddr_q  <= maddr_d;
      mpend_q  <= mpend_d;
      mop_q    <= mop_d;
      mdc_q    <= mdc_d;
      sticky_q <= sticky_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    wb_ack_o   = wb_ack_q;
    wb_dat_o   = wb_dat_q;
    core_ack   = core_ack_q;
    core_err   = core_err_q;
    core_rdata = core_rdata_q;
    mem_req    = (state_q == WBC_WB) | (state_q == WBC_RF);
    mem_we     = state_q == WBC_WB;
    mem_addr   = mem_we ? {vtag_q, idx_q[5:0], beat_q, 2'h0} : {line_q, beat_q, 2'h0};
    mem_wdata  = dc_data[idx_q[8:0]][beat_q];
  end
endmodule
`default_nettype wire

// ==== logic/wbc_params.svh ====
// Constants for the split write-back cache controller: offsets, fields, reset values and counts.
`ifndef WBC_PARAMS_SVH
`define WBC_PARAMS_SVH

// ****************************************************************
// Register offsets, byte addresses on the Wishbone slave
// ****************************************************************
`define WBC_OFS_CTRL      8'h00
`define WBC_OFS_CMD       8'h04
`define WBC_OFS_MADDR     8'h08
`define WBC_OFS_STAT      8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define WBC_CTRL_INJ_TAG  0
`define WBC_CTRL_INJ_DATA 1
`define WBC_CMD_OP_LSB    0
`define WBC_CMD_OP_MSB    1
`define WBC_CMD_DC        4
`define WBC_STAT_BUSY     0
`define WBC_STAT_TAG_ERR  1
`define WBC_STAT_DATA_ERR 2
`define WBC_STAT_BUS_ERR  3

// ****************************************************************
// Reset values
// ****************************************************************
`define WBC_CTRL_RST      2'h0
`define WBC_MADDR_RST     32'h0000_0000
`define WBC_STICKY_RST    3'h0

// ****************************************************************
// Geometry and counts
// ****************************************************************
`define WBC_IC_IDX_MSB    13
`define WBC_DC_IDX_MSB    12
`define WBC_IDX_LSB       4
`define WBC_PHYSICAL_TAG_FIELD_LSB      10
`define WBC_IC_LINES      1024
`define WBC_DC_LINES      512
`define WBC_LINE_WORDS    4
`define WBC_LAST_BEAT     2'h3

`endif

// ==== logic/wbc_pkg.sv ====
// Types shared by the split write-back cache controller.
package wbc_pkg;
  typedef logic [21:0] wbc_physical_tag_field_t;
  typedef enum logic [1:0] {
    WBC_IDLE,
    WBC_WB,
    WBC_RF
  } wbc_state_t;
  typedef enum logic [1:0] {
    WBC_OP_IDX_INV,
    WBC_OP_IDX_WBINV,
    WBC_OP_HIT_INV,
    WBC_OP_HIT_WBINV
  } wbc_mop_t;
endpackage

// ==== logic/wbc_tag_check.sv ====
// Tag compare and tag parity check for one cache line.
`timescale 1ns/100ps
`default_nettype none
module wbc_tag_check
  import wbc_pkg::*;
(
  input  wire logic      [21:0] stored_tag,
  input  wire logic      [2:0]  stored_flags,
  input  wire logic             stored_par,
  input  wire logic      [21:0] pa_tag,
  output logic                  hit,
  output logic                  tag_err
);
  // Flags are {valid, dirty, line_modified}; only a valid line can report an error.
  always_comb begin
    tag_err = stored_flags[2] & (stored_par != ^{stored_tag, stored_flags});
    // A corrupted tag is never trusted as a hit.
    hit     = stored_flags[2] & (stored_tag == pa_tag) & ~tag_err;
  end
endmodule
`default_nettype wire

// ==== dv/wbc_cache_ctrl_checker.sv ====
// Concurrent checks on the cache controller's Wishbone, core and memory ports.
`timescale 1ns/100ps
`default_nettype none
module wbc_cache_ctrl_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        core_req,
  input wire logic        core_ifetch,
  input wire logic        core_ack,
  input wire logic        core_err,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        mem_err
);
  // ********
  // Port properties
  // ********
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  a_wb_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("bus ack unasked");
  a_core_ack_pulse: assert property (core_ack |=> !core_ack)
    else $error("core ack too long");
  a_core_ack_cause: assert property (core_ack |-> $past(core_req))
    else $error("core ack unasked");
  a_err_with_ack: assert property (core_err |-> core_ack)
    else $error("core error without ack");
  a_fill_before_use: assert property (mem_req |-> !core_ack)
    else $error("core answered during line transfer");
  a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && (!mem_we || $stable(mem_wdata)))
    else $error("memory request changed before ack");
  a_burst_start: assert property ($rose(mem_req) |-> mem_addr[3:0] == 4'h0)
    else $error("line transfer not from word 0");
  a_burst_step: assert property (mem_req && mem_ack && !mem_err && mem_addr[3:2] != 2'h3
    |=> mem_req && mem_we == $past(mem_we) && mem_addr == $past(mem_addr) + 32'h4)
    else $error("line transfer word order broken");
  a_wb_then_fill: assert property (core_req && mem_ack && mem_we && mem_addr[3:2] == 2'h3
    |=> ##[0:3] (mem_req && !mem_we && mem_addr[3:0] == 4'h0))
    else $error("no refill after victim write-back");
  a_ifetch_no_wb: assert property (core_req && core_ifetch |-> !(mem_req && mem_we))
    else $error("instruction fetch wrote memory");
  c_write_back: cover property (mem_req && mem_we && mem_ack);
  c_core_err: cover property (core_ack && core_err);
  c_ifetch: cover property (core_ack && core_ifetch);
endmodule
`default_nettype wire

// ==== dv/wbc_mem_model.sv ====
// Behavioural main memory answering line refills and write-backs word by word.
`timescale 1ns/100ps
`default_nettype none
module wbc_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        slow,
  input  wire logic        err_en,
  output logic             mem_ack,
  output logic             mem_err,
  output logic      [31:0] mem_rdata
);
  // ********
  // Word store and answer timing
  // ********
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_q;
  initial begin
    mem_ack = 1'h0;
    mem_err = 1'h0;
    mem_rdata = 32'h0;
    wait_q = 2'h0;
  end
  // Data toggles outside an answer, so a stale word is never taken for a fresh one.
  always @(posedge sys_clk) begin
    mem_rdata <= ~mem_rdata;
    mem_ack <= 1'h0;
    mem_err <= 1'h0;
    wait_q <= 2'h0;
    if (mem_req && mem_ack && mem_we)
      mem[mem_addr] = mem_wdata;
    else if (mem_req && !mem_ack && wait_q >= {slow, slow}) begin
      mem_ack <= 1'h1;
      mem_err <= err_en && !mem_we;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : {mem_addr[15:0], ~mem_addr[15:0]};
    end else if (mem_req && !mem_ack)
      wait_q <= wait_q + 2'h1;
  end
endmodule
`default_nettype wire

// ==== dv/writeback_split_cache_controller_tb_top.sv ====
// Self-checking bench: registers, line fills, write-backs and maintenance.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_params.svh"
module writeback_split_cache_controller_tb_top
  import wbc_pkg::*;
;
  // ********
  // Signals, clock and monitors
  // ********
  logic        sys_clk = 1'h0;
  logic        srst = 1'h1;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        core_req = 1'h0;
  logic        core_ifetch = 1'h0;
  logic        core_we = 1'h0;
  logic [31:0] core_va = 32'h0;
  logic [31:0] core_pa = 32'h0;
  logic [3:0]  core_be = 4'hF;
  logic [31:0] core_wdata = 32'h0;
  logic        slow = 1'h0;
  logic        err_en = 1'h0;
  logic [31:0] wb_dat_o, core_rdata, mem_addr, mem_wdata, mem_rdata;
  logic        wb_ack_o, core_ack, core_err, mem_req, mem_we, mem_ack, mem_err;
  logic [31:0] seed = 32'h7CB4_46F1;
  logic [31:0] em [logic [31:0]];
  logic [31:0] wm [logic [31:0]];
  int          err_total = 0;
  int          n_tests = 0;
  int          nr = 0;
  int          nw = 0;
  int          cycles = 0;
  wbc_cache_ctrl dut (.*);
  wbc_mem_model  u_mem (.*);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      summarize();
    end
    if (mem_req === 1'h1 && mem_ack === 1'h1) begin
      if (mem_we) begin
        nw++;
        wm[mem_addr] = mem_wdata;
      end else
        nr++;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] mv(input logic [31:0] a);
    return em.exists(a) ? em[a] : {a[15:0], ~a[15:0]};
  endfunction
  task automatic summarize();
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic mop(input logic [31:0] a, input logic [31:0] cmd);
    logic [31:0] q;
    wb(1'h1, `WBC_OFS_MADDR, a, q);
    wb(1'h1, `WBC_OFS_CMD, cmd, q);
    do wb(1'h0, `WBC_OFS_STAT, 32'h0, q); while (q[`WBC_STAT_BUSY] !== 1'h0);
  endtask
  // A negative read count skips that count, for refills cut short by a bus error.
  task automatic acc(input logic f, input logic w, input logic [31:0] a, input logic [31:0] d,
                     input int er, input int ew, input logic [31:0] ed, input logic ee);
    logic [31:0] rv = rnd();
    int          n = 0;
    nr = 0;
    nw = 0;
    @(posedge sys_clk);
    core_req <= 1'h1;
    core_ifetch <= f;
    core_we <= w;
    core_va <= {rv[31:14], a[13:0]};
    core_pa <= a;
    core_wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (core_ack !== 1'h1);
    core_req <= 1'h0;
    if (!w && !ee) chk("rdata", core_rdata, ed);
    chk("err", {31'h0, core_err}, {31'h0, ee});
    if (er >= 0) chk("reads", nr, er);
    chk("writes", nw, ew);
    if (er == 0) chk("hit_lat", n, 2);
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] q, a, d;
    logic [7:0]  offs [4] = '{`WBC_OFS_CTRL, `WBC_OFS_MADDR, `WBC_OFS_STAT, 8'h10};
    repeat (5) @(posedge sys_clk);
    srst <= 1'h0;
    foreach (offs[i]) begin
      wb(1'h0, offs[i], 32'h0, q);
      chk("reg_rst", q, 32'h0);
    end
    d = rnd();
    wb(1'h1, `WBC_OFS_MADDR, d, q);
    wb(1'h0, `WBC_OFS_MADDR, 32'h0, q);
    chk("maddr", q, d);
    wb(1'h1, 8'h10, d, q);
    wb(1'h0, 8'h10, 32'h0, q);
    chk("unmapped", q, 32'h0);
    wb(1'h1, `WBC_OFS_CTRL, d, q);
    wb(1'h0, `WBC_OFS_CTRL, 32'h0, q);
    chk("ctrl", q, {30'h0, d[1:0]});
    wb(1'h1, `WBC_OFS_CTRL, 32'h0, q);
    for (int it = 0; it < 2; it++) begin
      slow <= it[0];
      for (int i = 0; i < `WBC_IC_LINES; i++) begin
        mop(32'(i) << 4, 32'h0);
        if (i < `WBC_DC_LINES) mop(32'(i) << 4, 32'h10);
      end
      a = rnd() & 32'hFFFF_CFFC;
      acc(1'h1, 1'h0, a, 32'h0, 4, 0, mv(a), 1'h0);
      acc(1'h1, 1'h0, a ^ 32'h2000, 32'h0, 4, 0, mv(a ^ 32'h2000), 1'h0);
      acc(1'h1, 1'h0, a, 32'h0, 0, 0, mv(a), 1'h0);
      acc(1'h0, 1'h0, a, 32'h0, 4, 0, mv(a), 1'h0);
      acc(1'h0, 1'h0, a ^ 32'h1000, 32'h0, 4, 0, mv(a ^ 32'h1000), 1'h0);
      d = rnd();
      acc(1'h0, 1'h1, a, d, 0, 0, 32'h0, 1'h0);
      acc(1'h0, 1'h0, a, 32'h0, 0, 0, d, 1'h0);
      wb(1'h1, `WBC_OFS_CTRL, 32'h2, q);
      d = rnd();
      acc(1'h0, 1'h1, a, d, 0, 0, 32'h0, 1'h0);
      wb(1'h1, `WBC_OFS_CTRL, 32'h0, q);
      acc(1'h0, 1'h0, a ^ 32'h2000, 32'h0, 4, 4, mv(a ^ 32'h2000), 1'h0);
      chk("wb_data", wm[a], d);
      em[a] = d;
      wb(1'h0, `WBC_OFS_STAT, 32'h0, q);
      chk("stat_err", q & 32'hE, 32'h4);
      wb(1'h1, `WBC_OFS_STAT, 32'hE, q);
      wb(1'h0, `WBC_OFS_STAT, 32'h0, q);
      chk("stat_clr", q & 32'hF, 32'h0);
      acc(1'h0, 1'h0, a, 32'h0, 4, 0, d, 1'h0);
      d = rnd();
      acc(1'h0, 1'h1, a ^ 32'h2000, d, 4, 0, 32'h0, 1'h0);
      nw = 0;
      mop(a ^ 32'h2000, {27'h0, 1'h1, 2'h0, WBC_OP_HIT_WBINV});
      chk("mop_wr", nw, 4);
      chk("mop_data", wm[a ^ 32'h2000], d);
      em[a ^ 32'h2000] = d;
      acc(1'h0, 1'h0, a ^ 32'h2000, 32'h0, 4, 0, d, 1'h0);
      err_en <= 1'h1;
      acc(1'h0, 1'h0, a ^ 32'h3000, 32'h0, -1, 0, 32'h0, 1'h1);
      err_en <= 1'h0;
      acc(1'h0, 1'h0, a ^ 32'h3000, 32'h0, 4, 0, mv(a ^ 32'h3000), 1'h0);
      wb(1'h1, `WBC_OFS_CTRL, 32'h1, q);
      acc(1'h0, 1'h1, a ^ 32'h3000, d, 0, 0, 32'h0, 1'h0);
      wb(1'h1, `WBC_OFS_CTRL, 32'h0, q);
      acc(1'h0, 1'h0, a ^ 32'h3000, 32'h0, 0, 0, 32'h0, 1'h1);
      wb(1'h0, `WBC_OFS_STAT, 32'h0, q);
      chk("stat_terr", q & 32'hE, 32'hA);
      wb(1'h1, `WBC_OFS_STAT, 32'hE, q);
      mop(a ^ 32'h3000, 32'h10);
    end
    summarize();
  end
endmodule
bind wbc_cache_ctrl wbc_cache_ctrl_checker u_chk (.*);
`default_nettype wire
